// ===== bench/test_timer_b_counter_core.sv
// Self-checking bench of the timer core over its register bus
`timescale 1ns/1ps
`include "tmb_map.vh"
module test_timer_b_counter_core;
    localparam logic [7:0] ix_cs = `TMB_IDX_CTRL_STAT;
    localparam logic [7:0] ix_hi = `TMB_IDX_COUNT_HI;
    localparam logic [7:0] ix_lo = `TMB_IDX_COUNT_LO;
    localparam logic [7:0] ix_mh = `TMB_IDX_MODULO_HI;
    localparam logic [7:0] ix_ml = `TMB_IDX_MODULO_LO;
    localparam logic [7:0] ix_c0 = `TMB_IDX_CHAN0_CTRL;
    localparam logic [7:0] ix_ch = `TMB_IDX_CHAN0_HI;
    localparam logic [7:0] ix_cl = `TMB_IDX_CHAN0_LO;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic wt = 1'b0, stp = 1'b0, brk = 1'b0, cp = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic [31:0] wd = 32'h0;
    wire [31:0] rdat;
    wire [1:0] rrsp, brsp;
    wire awr, wrr, arr, rv, bv, irq, ext, cout, coe_n, cirq;
    logic [7:0] d;
    logic [1:0] r, lb;
    logic [15:0] v, u;
    int fails = 0, compares = 0, cyc = 0;

    always #5 i_clk = ~i_clk;
    tmb_ext_src u_src (.o_pin(ext));
    tmb_core dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_wait_mode(wt),
        .i_stop_mode(stp), .i_break_active(brk), .i_break_clear_enable(1'b0),
        .i_ext_count_clk_pin(ext), .i_chan0_pin(cp), .o_chan0_out(cout), .o_chan0_oe_n(coe_n),
        .o_wrap_irq(irq), .o_chan0_irq(cirq), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
        .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf),
        .i_s_axi_wvalid(wv), .o_s_axi_wready(wrr), .o_s_axi_bresp(brsp), .o_s_axi_bvalid(bv),
        .i_s_axi_bready(bry), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
        .o_s_axi_arready(arr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rrsp),
        .o_s_axi_rvalid(rv), .i_s_axi_rready(rry));

    task automatic end_sim;
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic rng(input string n, input logic [15:0] lo, hi, g);
        compares++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            fails++;
            $display("BAD %s exp %h..%h got %h", n, lo, hi, g);
        end
    endtask

    // Address and data go out together; each drops once taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        awa <= {2'b00, idx, 2'b00};
        wd <= {24'h0, dat};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        while (!(a && w)) begin
            @(posedge i_clk);
            if (!a && awr) begin
                a = 1'b1;
                awv <= 1'b0;
            end
            if (!w && wrr) begin
                w = 1'b1;
                wv <= 1'b0;
            end
        end
        while (bv !== 1'b1) @(posedge i_clk);
        lb = brsp;
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] o, output logic [1:0] e);
        ara <= {2'b00, idx, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        @(posedge i_clk);
        while (arr !== 1'b1) @(posedge i_clk);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge i_clk);
        o = rdat[7:0];
        e = rrsp;
    endtask

    task automatic rc(output logic [15:0] c);
        logic [7:0] h, l;
        logic [1:0] e;
        rd(ix_hi, h, e);
        rd(ix_lo, l, e);
        c = {h, l};
    endtask

    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (irq !== e && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        chk("wrap_irq", {15'h0, e}, {15'h0, irq});
    endtask

    task automatic t_reset;
        rd(ix_cs, d, r);
        chk("ctrl_stat", 16'h20, {8'h0, d});
        repeat (20) @(posedge i_clk);
        rc(v);
        chk("count", 16'h0, v);
        rd(8'h00, d, r);
        chk("unmapped", 16'h200, {6'h0, r, d});
    endtask

    task automatic t_presc;
        int e;
        for (int s = 0; s < 7; s++) begin
            e = 1024 >> s;
            wr(ix_cs, {5'b00111, s[2:0]});
            rc(v);
            chk("cleared", 16'h0, v);
            wr(ix_cs, {5'b00000, s[2:0]});
            repeat (1024) @(posedge i_clk);
            wr(ix_cs, {5'b00100, s[2:0]});
            rc(v);
            rng("divided", e[15:0], e[15:0] + 16'd8, v);
        end
    endtask

    // Modulo zero wraps on every tick, so any gap lets a wrap intervene
    task automatic t_wrap;
        wr(ix_cs, 8'h30);
        wr(ix_mh, 8'h00);
        wr(ix_ml, 8'h00);
        wr(ix_mh, 8'h00);
        wr(ix_cs, 8'h40);
        repeat (40) @(posedge i_clk);
        chk("held irq", 16'h0, {15'h0, irq});
        rd(ix_cs, d, r);
        chk("held flag", 16'h0, {15'h0, d[7]});
        wr(ix_ml, 8'h00);
        wait_irq(1'b1);
        rd(ix_cs, d, r);
        wr(ix_cs, 8'h60);
        rd(ix_cs, d, r);
        chk("flag kept", 16'h1, {15'h0, d[7]});
        wr(ix_cs, 8'ha0);
        wait_irq(1'b0);
        wr(ix_cs, 8'he0);
        wait_irq(1'b1);
        rd(ix_cs, d, r);
        wr(ix_cs, 8'h60);
        wait_irq(1'b0);
        rd(ix_cs, d, r);
        chk("flag clr", 16'h0, {15'h0, d[7]});
        wr(ix_mh, 8'hff);
        wr(ix_ml, 8'hff);
    endtask

    task automatic t_latch;
        wr(ix_cs, 8'h30);
        rd(ix_hi, d, r);
        wr(ix_cs, 8'h00);
        repeat (300) @(posedge i_clk);
        wr(ix_cs, 8'h20);
        rd(ix_lo, d, r);
        chk("latched lo", 16'h0, {8'h0, d});
        rc(v);
        rng("count", 16'd300, 16'd320, v);
    endtask

    task automatic t_freeze(input logic b);
        wr(ix_cs, 8'h00);
        stp <= !b;
        brk <= b;
        @(posedge i_clk);
        rc(v);
        repeat (50) @(posedge i_clk);
        rc(u);
        chk("frozen", v, u);
        stp <= 1'b0;
        brk <= 1'b0;
        repeat (50) @(posedge i_clk);
        rc(u);
        rng("resumed", v + 16'd50, v + 16'd80, u);
    endtask

    task automatic t_wait;
        rc(v);
        wt <= 1'b1;
        @(posedge i_clk);
        rd(ix_cs, d, r);
        chk("wait resp", 16'h2, {14'h0, r});
        wr(ix_cs, 8'h20);
        chk("wait bresp", 16'h2, {14'h0, lb});
        repeat (50) @(posedge i_clk);
        wt <= 1'b0;
        @(posedge i_clk);
        rc(u);
        rng("wait count", v + 16'd50, v + 16'd90, u);
    endtask

    task automatic t_ext;
        wr(ix_cs, 8'h37);
        wr(ix_cs, 8'h07);
        u_src.burst(10);
        repeat (10) @(posedge i_clk);
        rc(v);
        chk("ext count", 16'd10, v);
    endtask

    task automatic ones(output int n);
        n = 0;
        repeat (32) begin
            @(posedge i_clk);
            n += cout;
        end
    endtask

    // Clear on compare without toggle-on-wrap, full duty, flag under break, capture
    task automatic t_chan;
        int n;
        wr(ix_cs, 8'h30);
        wr(ix_mh, 8'h00);
        wr(ix_ml, 8'h0f);
        wr(ix_ch, 8'h00);
        wr(ix_cl, 8'h05);
        wr(ix_c0, 8'h68);
        @(posedge i_clk);
        chk("pair oe_n", 16'h0, {15'h0, coe_n});
        wr(ix_cs, 8'h00);
        repeat (16) @(posedge i_clk);
        ones(n);
        chk("zero duty", 16'h0, n[15:0]);
        chk("chan irq", 16'h1, {15'h0, cirq});
        wr(ix_c0, 8'h69);
        ones(n);
        chk("full duty", 16'd32, n[15:0]);
        wr(ix_cs, 8'h20);
        rd(ix_c0, d, r);
        chk("chan flag", 16'he9, {8'h0, d});
        brk <= 1'b1;
        wr(ix_c0, 8'h68);
        rd(ix_c0, d, r);
        chk("break flag", 16'h1, {15'h0, d[7]});
        brk <= 1'b0;
        wr(ix_c0, 8'h68);
        rd(ix_c0, d, r);
        chk("flag after", 16'h0, {15'h0, d[7]});
        wr(ix_c0, 8'h44);
        cp <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd(ix_c0, d, r);
        chk("halt capture", 16'h0, {15'h0, d[7]});
        cp <= 1'b0;
        wr(ix_cs, 8'h00);
        repeat (8) @(posedge i_clk);
        cp <= 1'b1;
        repeat (8) @(posedge i_clk);
        rd(ix_c0, d, r);
        chk("capture", 16'h1, {15'h0, d[7]});
        chk("cap oe_n", 16'h1, {15'h0, coe_n});
        cp <= 1'b0;
    endtask

    initial begin
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        t_reset;
        t_presc;
        t_wrap;
        t_latch;
        t_freeze(1'b0);
        t_freeze(1'b1);
        t_wait;
        t_chan;
        t_ext;
        end_sim;
    end

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            end_sim;
        end
    end
endmodule

// ===== bench/tmb_core_asserts.sv
// Port checks of the timer core: bus answers and reset state
`timescale 1ns/1ps
module tmb_core_chk (
    // Clock, reset and wait mode
    input wire i_clk,
    input wire i_reset,
    input wire i_wait_mode,
    // Bus
    input wire i_s_axi_awvalid,
    input wire o_s_axi_awready,
    input wire i_s_axi_wvalid,
    input wire o_s_axi_wready,
    input wire o_s_axi_bvalid,
    input wire [11:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    input wire o_s_axi_arready,
    input wire [31:0] o_s_axi_rdata,
    input wire [1:0] o_s_axi_rresp,
    input wire o_s_axi_rvalid,
    // Outputs
    input wire o_wrap_irq,
    input wire o_chan0_out,
    input wire o_chan0_oe_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire ar = i_s_axi_arvalid && o_s_axi_arready;

    a_reset_state: assert property ($fell(i_reset) |-> !o_s_axi_bvalid &&
        !o_s_axi_rvalid && !o_wrap_irq && o_chan0_out && o_chan0_oe_n)
        else $error("outputs not idle after reset");
    a_read_answer: assert property (ar |=> o_s_axi_rvalid)
        else $error("read answer late");
    a_wait_err: assert property (ar && i_wait_mode |=> o_s_axi_rresp == 2'h2)
        else $error("read in wait mode not refused");
    a_clear_reads0: assert property (ar && !i_wait_mode &&
        i_s_axi_araddr == 12'h100 |=> !o_s_axi_rdata[4])
        else $error("counter clear bit read back as one");
    a_unmapped_err: assert property (ar && i_s_axi_araddr == 12'h000 |=>
        o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_upper_zero: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_ar_busy: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read address taken while answer pending");
    a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready &&
        i_s_axi_wvalid && o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid)
        else $error("write answer late");
endmodule

bind tmb_core tmb_core_chk u_chk (.i_clk, .i_reset, .i_wait_mode, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_araddr,
    .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
    .o_wrap_irq, .o_chan0_out, .o_chan0_oe_n);

// ===== bench/tmb_ext_src.sv
// Model of the external count clock source that feeds the external count clock pin, whose edges bypass the prescaler
`timescale 1ns/1ps
module tmb_ext_src (
    // Pin
    output logic o_pin
);
    // The source stands low between bursts
    initial o_pin = 1'b0;
    // 300 ns period stays below 4 MHz and half the bus clock
    task automatic burst(input int n);
        // Offset keeps every pin change away from a sampling edge
        #3;
        repeat (n) begin
            #155 o_pin = 1'b1;
            #145 o_pin = 1'b0;
        end
    endtask
endmodule

// ===== rtl/tmb_core.v
// Timer core: prescaled counter, modulo wrap, channel 0 and AXI4-Lite registers
`timescale 1ns/1ps
`include "tmb_map.vh"

module tmb_core (
    // Clock, reset, enable
    input wire i_clk,
    input wire i_reset,
    input wire i_ce,
    // System state
    input wire i_wait_mode,
    input wire i_stop_mode,
    input wire i_break_active,
    input wire i_break_clear_enable,
    // Pins
    input wire i_ext_count_clk_pin,
    input wire i_chan0_pin,
    output wire o_chan0_out,
    output wire o_chan0_oe_n,
    // Interrupt requests
    output wire o_wrap_irq,
    output wire o_chan0_irq,
    // AXI4-Lite write
    input wire [11:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output wire o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output wire o_s_axi_wready,
    output wire [1:0] o_s_axi_bresp,
    output wire o_s_axi_bvalid,
    input wire i_s_axi_bready,
    // AXI4-Lite read
    input wire [11:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output wire o_s_axi_arready,
    output wire [31:0] o_s_axi_rdata,
    output wire [1:0] o_s_axi_rresp,
    output wire o_s_axi_rvalid,
    input wire i_s_axi_rready
);

    function [5:0] div_mask;
        input [2:0] sel;
        begin
            div_mask = 6'h3f >> (3'h6 - sel);
            if (sel == 3'h0) begin
                div_mask = 6'h00;
            end
        end
    endfunction

    function mapped;
        input [9:0] addr;
        begin
            mapped = (addr[9:8] == 2'h0) && (addr[7:0] >= `TMB_IDX_CTRL_STAT)
                && (addr[7:0] <= `TMB_IDX_CHAN0_LO);
        end
    endfunction

    // Bus state
    reg awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    reg aw_have_r, w_have_r;
    reg [9:0] awaddr_r;
    reg [7:0] wdata_r;
    reg wstrb_r;
    reg [1:0] bresp_r, rresp_r;
    reg [7:0] rdata_r;
    // Timer state
    reg [15:0] cnt_r, mod_r, ch_r;
    reg [5:0] presc_r;
    reg [2:0] div_sel_r;
    reg halt_r, wrap_flag_r, wrap_irq_en_r, wrap_arm_r, mod_pend_r;
    reg lo_latched_r;
    reg [7:0] lo_buf_r;
    reg [7:0] chan_ctrl_r;
    reg chan_arm_r, ch_pend_r, cap_inh_r, out_r, oe_n_r;
    reg wrap_irq_r, chan_irq_r;
    // Pin synchronisers
    reg ext_s1_r, ext_s2_r, ext_s3_r, ext_lvl_r;
    reg pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r;

    assign o_s_axi_awready = awready_r;
    assign o_s_axi_wready = wready_r;
    assign o_s_axi_bvalid = bvalid_r;
    assign o_s_axi_bresp = bresp_r;
    assign o_s_axi_arready = arready_r;
    assign o_s_axi_rvalid = rvalid_r;
    assign o_s_axi_rresp = rresp_r;
    assign o_s_axi_rdata = {24'h000000, rdata_r};
    assign o_chan0_out = out_r;
    assign o_chan0_oe_n = oe_n_r;
    assign o_wrap_irq = wrap_irq_r;
    assign o_chan0_irq = chan_irq_r;

    // Decoded channel mode
    wire [1:0] edge_sel = chan_ctrl_r[`TMB_CH_EDGE_B:`TMB_CH_EDGE_A];
    wire cmp_mode = (chan_ctrl_r[`TMB_CH_PAIR_BUF] | chan_ctrl_r[`TMB_CH_MODE_A])
        & (edge_sel != 2'h0);
    wire cap_mode = ~chan_ctrl_r[`TMB_CH_PAIR_BUF] & ~chan_ctrl_r[`TMB_CH_MODE_A]
        & (edge_sel != 2'h0);
    wire tov = chan_ctrl_r[`TMB_CH_TOGGLE_WRAP];

    // Bus transactions; wait mode refuses register access
    wire wr_fire = aw_have_r & w_have_r & ~bvalid_r;
    wire wr_ok = wr_fire & mapped(awaddr_r) & ~i_wait_mode;
    wire wr_en = wr_ok & wstrb_r;
    wire [7:0] widx = awaddr_r[7:0];
    wire rd_fire = i_s_axi_arvalid & arready_r;
    wire rd_ok = rd_fire & mapped(i_s_axi_araddr[11:2]) & ~i_wait_mode;
    wire [7:0] ridx = i_s_axi_araddr[9:2];
    wire flag_lock = i_break_active & ~i_break_clear_enable;

    // Counting
    wire ext_edge = (ext_s2_r == ext_s3_r) & ext_s3_r & ~ext_lvl_r;
    wire div_tick = (div_sel_r == `TMB_DIV_EXT) ? ext_edge
        : ((presc_r & div_mask(div_sel_r)) == div_mask(div_sel_r));
    wire run = ~halt_r & ~i_stop_mode & ~i_break_active;
    wire tick = run & div_tick;
    wire wrap = tick & (cnt_r == mod_r);
    wire [15:0] cnt_inc = wrap ? 16'h0000 : cnt_r + 16'h0001;
    wire wrap_set = wrap & ~mod_pend_r;
    wire clr_write = wr_en & (widx == `TMB_IDX_CTRL_STAT) & wdata_r[`TMB_COUNTER_CLEAR];

    // Channel events
    wire pin_stable = pin_s2_r == pin_s3_r;
    wire pin_rise = pin_stable & pin_s3_r & ~pin_lvl_r;
    wire pin_fall = pin_stable & ~pin_s3_r & pin_lvl_r;
    wire cap_edge = (edge_sel[0] & pin_rise) | (edge_sel[1] & pin_fall);
    wire capture = cap_mode & cap_edge & ~halt_r & ~i_break_active & ~i_stop_mode
        & ~cap_inh_r;
    wire match = cmp_mode & tick & ~ch_pend_r & ~clr_write & (cnt_inc == ch_r);
    wire chan_set = capture | match;

    // Read data mux
    reg [7:0] rd_val;
    always @* begin
        rd_val = 8'h00;
        if (ridx == `TMB_IDX_CTRL_STAT) begin
            rd_val = {wrap_flag_r, wrap_irq_en_r, halt_r, 2'b00, div_sel_r};
        end else if (ridx == `TMB_IDX_COUNT_HI) begin
            rd_val = cnt_r[15:8];
        end else if (ridx == `TMB_IDX_COUNT_LO) begin
            rd_val = lo_latched_r ? lo_buf_r : cnt_r[7:0];
        end else if (ridx == `TMB_IDX_MODULO_HI) begin
            rd_val = mod_r[15:8];
        end else if (ridx == `TMB_IDX_MODULO_LO) begin
            rd_val = mod_r[7:0];
        end else if (ridx == `TMB_IDX_CHAN0_CTRL) begin
            rd_val = chan_ctrl_r;
        end else if (ridx == `TMB_IDX_CHAN0_HI) begin
            rd_val = ch_r[15:8];
        end else if (ridx == `TMB_IDX_CHAN0_LO) begin
            rd_val = ch_r[7:0];
        end
    end

    // AXI4-Lite slave
    always @(posedge i_clk) begin
        if (i_reset) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            arready_r <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            awaddr_r <= 10'h000;
            wdata_r <= 8'h00;
            wstrb_r <= 1'b0;
            bresp_r <= `TMB_RESP_OK;
            rresp_r <= `TMB_RESP_OK;
            rdata_r <= 8'h00;
        end else if (i_ce) begin
            if (i_s_axi_awvalid & awready_r) begin
                awready_r <= 1'b0;
                aw_have_r <= 1'b1;
                awaddr_r <= i_s_axi_awaddr[11:2];
            end
            if (i_s_axi_wvalid & wready_r) begin
                wready_r <= 1'b0;
                w_have_r <= 1'b1;
                wdata_r <= i_s_axi_wdata[7:0];
                wstrb_r <= i_s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? `TMB_RESP_OK : `TMB_RESP_ERR;
            end
            if (bvalid_r & i_s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
            if (rd_fire) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_ok ? rd_val : 8'h00;
                rresp_r <= rd_ok ? `TMB_RESP_OK : `TMB_RESP_ERR;
            end
            if (rvalid_r & i_s_axi_rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // Pin synchronisers; a change counts once the second and third stages agree
    always @(posedge i_clk) begin
        if (i_reset) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            ext_lvl_r <= 1'b0;
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
            pin_lvl_r <= 1'b0;
        end else if (i_ce) begin
            ext_s1_r <= i_ext_count_clk_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            pin_s1_r <= i_chan0_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (ext_s2_r == ext_s3_r) begin
                ext_lvl_r <= ext_s3_r;
            end
            if (pin_stable) begin
                pin_lvl_r <= pin_s3_r;
            end
        end
    end

    // Counter, prescaler and timer control
    always @(posedge i_clk) begin
        if (i_reset) begin
            cnt_r <= `TMB_RST_COUNT;
            presc_r <= 6'h00;
            div_sel_r <= 3'h0;
            halt_r <= 1'b1;
            wrap_flag_r <= 1'b0;
            wrap_irq_en_r <= 1'b0;
            wrap_arm_r <= 1'b0;
            mod_r <= `TMB_RST_MODULO;
            mod_pend_r <= 1'b0;
            lo_latched_r <= 1'b0;
            lo_buf_r <= 8'h00;
            wrap_irq_r <= 1'b0;
        end else if (i_ce) begin
            if (run) begin
                presc_r <= presc_r + 6'h01;
            end
            if (tick) begin
                cnt_r <= cnt_inc;
            end
            if (clr_write) begin
                cnt_r <= 16'h0000;
                presc_r <= 6'h00;
            end
            if (rd_ok && ridx == `TMB_IDX_CTRL_STAT && wrap_flag_r && !flag_lock) begin
                wrap_arm_r <= 1'b1;
            end
            if (rd_ok && ridx == `TMB_IDX_COUNT_HI && !lo_latched_r) begin
                lo_latched_r <= 1'b1;
                lo_buf_r <= cnt_r[7:0];
            end
            if (rd_ok && ridx == `TMB_IDX_COUNT_LO) begin
                lo_latched_r <= 1'b0;
            end
            if (wr_en) begin
                if (widx == `TMB_IDX_CTRL_STAT) begin
                    wrap_irq_en_r <= wdata_r[`TMB_WRAP_IRQ_EN];
                    halt_r <= wdata_r[`TMB_COUNTER_HALT];
                    div_sel_r <= wdata_r[`TMB_DIV_SEL_HI:0];
                    // Only a zero after an armed read clears; a one does nothing
                    if (!wdata_r[`TMB_WRAP_FLAG] && wrap_arm_r && !flag_lock) begin
                        wrap_flag_r <= 1'b0;
                        wrap_arm_r <= 1'b0;
                    end
                end else if (widx == `TMB_IDX_MODULO_HI) begin
                    mod_r[15:8] <= wdata_r;
                    mod_pend_r <= 1'b1;
                end else if (widx == `TMB_IDX_MODULO_LO) begin
                    mod_r[7:0] <= wdata_r;
                    mod_pend_r <= 1'b0;
                end
            end
            // A new wrap beats a clear in the same cycle and voids the armed read
            if (wrap_set) begin
                wrap_flag_r <= 1'b1;
                wrap_arm_r <= 1'b0;
            end
            wrap_irq_r <= (wrap_flag_r | wrap_set) & wrap_irq_en_r;
        end
    end

    // Channel 0
    always @(posedge i_clk) begin
        if (i_reset) begin
            chan_ctrl_r <= `TMB_RST_CHAN0_CTRL;
            chan_arm_r <= 1'b0;
            ch_r <= 16'h0000;
            ch_pend_r <= 1'b0;
            cap_inh_r <= 1'b0;
            out_r <= 1'b1;
            oe_n_r <= 1'b1;
            chan_irq_r <= 1'b0;
        end else if (i_ce) begin
            if (rd_ok && ridx == `TMB_IDX_CHAN0_CTRL && chan_ctrl_r[`TMB_CH_FLAG]
                && !flag_lock) begin
                chan_arm_r <= 1'b1;
            end
            if (rd_ok && ridx == `TMB_IDX_CHAN0_HI && cap_mode) begin
                cap_inh_r <= 1'b1;
            end
            if (rd_ok && ridx == `TMB_IDX_CHAN0_LO) begin
                cap_inh_r <= 1'b0;
            end
            if (wr_en) begin
                if (widx == `TMB_IDX_CHAN0_CTRL) begin
                    chan_ctrl_r[6:0] <= wdata_r[6:0];
                    if (!wdata_r[`TMB_CH_FLAG] && chan_arm_r && !flag_lock) begin
                        chan_ctrl_r[`TMB_CH_FLAG] <= 1'b0;
                        chan_arm_r <= 1'b0;
                    end
                end else if (widx == `TMB_IDX_CHAN0_HI) begin
                    ch_r[15:8] <= wdata_r;
                    ch_pend_r <= 1'b1;
                end else if (widx == `TMB_IDX_CHAN0_LO) begin
                    ch_r[7:0] <= wdata_r;
                    ch_pend_r <= 1'b0;
                end
            end
            if (capture) begin
                ch_r <= cnt_r;
            end
            if (chan_set) begin
                chan_ctrl_r[`TMB_CH_FLAG] <= 1'b1;
                chan_arm_r <= 1'b0;
            end
            chan_irq_r <= (chan_ctrl_r[`TMB_CH_FLAG] | chan_set)
                & chan_ctrl_r[`TMB_CH_IRQ_EN];
            oe_n_r <= ~cmp_mode;
            // Unconnected channel presets its level; compare mode acts on events
            if (edge_sel == 2'h0) begin
                out_r <= ~chan_ctrl_r[`TMB_CH_MODE_A];
            end else if (cmp_mode) begin
                if (chan_ctrl_r[`TMB_CH_FULL_DUTY] && !tov) begin
                    out_r <= 1'b1;
                end else if (wrap && tov) begin
                    out_r <= ~out_r;
                end else if (match) begin
                    // Without toggle-on-wrap a forced level repeats: clear on compare gives 0% duty, set gives 100%
                    if (edge_sel == 2'h1) begin
                        out_r <= ~out_r;
                    end else begin
                        out_r <= edge_sel[0];
                    end
                end
            end
        end
    end

endmodule

// ===== rtl/tmb_map.vh
// Register indices, field positions, reset values and timing figures of the timer core
// Notes on behaviour
// - Pair buffer select overrides mode select A.
// - Toggle-on-wrap clear: no toggle on wrap.
// - Full-duty force with toggle clear gives 100%.
// - Wrap flag sets when counter rolls to zero.
// - Wrap request only when flag and enable set.
// - Channel flag on capture/compare, gated request.
// - Wait mode keeps counting; registers unreachable.
// - Stop mode halts, keeps counter and registers.
// - Break holds counter and blocks captures.
// - Break without clear enable protects status flags.
// - Select all ones picks external count clock.
// - Flag clear: read set, write zero; guarded.
// - Halt bit freezes counting; reset sets it.
// - Halt blocks input captures.
// - Counter clear zeroes counter and prescaler, self-clears.
// - Halt plus clear leaves counter stopped zero.
// - Select codes divide bus clock 1 to 64.
// - High read latches low byte until read.
// - Reset clears counter, select, flag, enable.
// - Modulo high write suppresses wrap flag until low; counter still wraps.
`ifndef TMB_MAP_VH
`define TMB_MAP_VH

// Register indices; byte address is four times the index
`define TMB_IDX_CTRL_STAT 8'h40
`define TMB_IDX_COUNT_HI 8'h41
`define TMB_IDX_COUNT_LO 8'h42
`define TMB_IDX_MODULO_HI 8'h43
`define TMB_IDX_MODULO_LO 8'h44
`define TMB_IDX_CHAN0_CTRL 8'h45
`define TMB_IDX_CHAN0_HI 8'h46
`define TMB_IDX_CHAN0_LO 8'h47

// timer_ctrl_stat fields
`define TMB_WRAP_FLAG 7
`define TMB_WRAP_IRQ_EN 6
`define TMB_COUNTER_HALT 5
`define TMB_COUNTER_CLEAR 4
`define TMB_DIV_SEL_HI 2
`define TMB_DIV_EXT 3'h7

// chan0_ctrl_stat fields
`define TMB_CH_FLAG 7
`define TMB_CH_IRQ_EN 6
`define TMB_CH_PAIR_BUF 5
`define TMB_CH_MODE_A 4
`define TMB_CH_EDGE_B 3
`define TMB_CH_EDGE_A 2
`define TMB_CH_TOGGLE_WRAP 1
`define TMB_CH_FULL_DUTY 0

// Reset values
`define TMB_RST_CTRL_STAT 8'h20
`define TMB_RST_CHAN0_CTRL 8'h00
`define TMB_RST_MODULO 16'hffff
`define TMB_RST_COUNT 16'h0000

// Timing figures
`define TMB_CLK_PERIOD_NS 10
`define TMB_EXT_CLK_MAX_KHZ 4000
`define TMB_EXT_MIN_HALF_CYC 2

// Bus responses
`define TMB_RESP_OK 2'h0
`define TMB_RESP_ERR 2'h2

`endif
